// ### rtl/acrb_pkg.sv
// Purpose: constants for the converter configuration register bank
// Assumes: 8-bit registers, 10-bit register addresses
// Notes: Operation list below
// Operation
// - load defaults after 2^20 clocks from power-on
// - hardware reset pin restores all defaults
// - decode addresses 0x00 through 0x15D
// - all registers read/write; bit 7 of 0x59-0x5D and 0x62 reads zero
// - each register is eight volatile bits
// - every register reached by address command
// - 0x00 mirrored mode pairs, default 0x24
// - 0x01 rate enable and channel count, 0x0F
// - 0x04 readback edge select, default 0x9F
// - 0x07 strobe, autocal, scrambler, default 0x62
// - 0x62 format and test pattern, 0x10
// - 0x65 lane polarity mask, default 0x00
// - 0x59 synth enables, default 0x41
// - 0x5A filter resistor code, default 0x2F
// - access is header then data bytes
// - address counter increments, never wraps
package acrb_pkg;
   localparam int unsigned ADDR_W        = 10;
   localparam int unsigned POR_DELAY_LOG = 20;
   localparam logic [9:0]  ADDR_LAST     = 10'h15D;
   localparam int unsigned NUM_REGS      = 23;
   // offset, default, writable mask; table order
   localparam logic [9:0] REG_ADDR [NUM_REGS] = '{
      10'h000, 10'h001, 10'h002, 10'h004, 10'h007, 10'h01E, 10'h052, 10'h053,
      10'h054, 10'h055, 10'h056, 10'h057, 10'h058, 10'h059, 10'h05A, 10'h05B,
      10'h05C, 10'h05D, 10'h05F, 10'h062, 10'h063, 10'h064, 10'h065};
   localparam logic [7:0] REG_RST [NUM_REGS] = '{
      8'h24, 8'h0F, 8'h00, 8'h9F, 8'h62, 8'h80, 8'h0A, 8'h45,
      8'h00, 8'h48, 8'h78, 8'h40, 8'h12, 8'h41, 8'h2F, 8'h27,
      8'h27, 8'h27, 8'hF1, 8'h10, 8'h01, 8'h03, 8'h00};
   localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F,
      8'h7F, 8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF};
   localparam int unsigned IDX_MODE  = 0;
   localparam int unsigned IDX_CHAN  = 1;
   localparam int unsigned IDX_SDO   = 3;
   localparam int unsigned IDX_SCR   = 4;
   localparam int unsigned IDX_SEN1  = 13;
   localparam int unsigned IDX_SRES  = 14;
   localparam int unsigned IDX_FMT   = 19;
   localparam int unsigned IDX_POL   = 22;
endpackage : acrb_pkg

// ### rtl/acrb_bank.sv
// Purpose: configuration register bank behind the serial port engine
// Assumes: engine delivers one byte per strobe with a start address
// Notes: unmapped reads return zero; all map entries are stored in this bank
`timescale 1ns/1ps
module acrb_bank #(
   parameter int unsigned POR_CYCLES = 1 << acrb_pkg::POR_DELAY_LOG
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   input  wire logic                      hw_reset_n_pin,
   input  wire logic                      cmd_start,
   input  wire logic [acrb_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic                      byte_write,
   input  wire logic                      byte_read,
   input  wire logic [7:0]                byte_wdata,
   output logic      [7:0]                byte_rdata,
   output logic                           cfg_ready,
   output logic                           shutdown,
   output logic                           lsb_first,
   output logic                           soft_reinit_n,
   output logic                           standby,
   output logic                           independent_rate_enable,
   output logic      [2:0]                active_channel_count,
   output logic                           readback_edge_select,
   output logic                           frame_strobe_polarity,
   output logic                           autocal_delay_enable,
   output logic                           scrambler_enable,
   output logic                           eight_lane_serial_mode,
   output logic                           sample_format,
   output logic      [1:0]                output_if_select,
   output logic      [2:0]                test_pattern_select,
   output logic      [7:0]                lane_polarity_invert,
   output logic                           synth_refdiv_enable,
   output logic                           synth_enable,
   output logic      [4:0]                synth_filter_resistor_code
);
   import acrb_pkg::*;

   logic       rpin_s1_q;
   logic       rpin_s2_q;
   logic [20:0] por_cnt_q, por_cnt_d;
   logic       ready_q, ready_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [ADDR_W-1:0] acc_addr;
   logic [7:0] regs_q [NUM_REGS];
   logic [7:0] regs_d [NUM_REGS];
   logic [7:0] rdata_q, rdata_d;
   logic       load_defaults;

   // pin passes two flops before use
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rpin_s1_q <= 1'b1;
         rpin_s2_q <= 1'b1;
      end else begin
         rpin_s1_q <= hw_reset_n_pin;
         rpin_s2_q <= rpin_s1_q;
      end
   end

   // power-on wait; pin reset restores defaults without rerunning the wait
   always_comb begin
      por_cnt_d = por_cnt_q;
      ready_d   = ready_q;
      if (!ready_q) begin
         if (por_cnt_q == 21'(POR_CYCLES - 1)) begin
            ready_d = 1'b1;
         end else begin
            por_cnt_d = por_cnt_q + 21'h000001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         por_cnt_q <= '0;
         ready_q   <= 1'b0;
      end else begin
         por_cnt_q <= por_cnt_d;
         ready_q   <= ready_d;
      end
   end

   assign load_defaults = (!ready_q) || (!rpin_s2_q);

   // a byte taken with the start strobe already counts as the first step
   assign acc_addr = cmd_start ? cmd_addr : addr_q;

   // address counter: steps per byte, saturates at the last address
   always_comb begin
      addr_d = acc_addr;
      if ((byte_write || byte_read) && acc_addr != ADDR_LAST) begin
         addr_d = acc_addr + 10'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         addr_q <= '0;
      end else begin
         addr_q <= addr_d;
      end
   end

   // per-register storage with write masks

   for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_comb begin
         regs_d[i] = regs_q[i];
         if (load_defaults) begin
            regs_d[i] = REG_RST[i];
         end else if (byte_write && acc_addr == REG_ADDR[i]) begin
            regs_d[i] = (regs_q[i] & ~REG_WMASK[i]) | (byte_wdata & REG_WMASK[i]);
         end
      end
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            regs_q[i] <= REG_RST[i];
         end else begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   // read mux; only bank addresses answer
   always_comb begin
      rdata_d = rdata_q;
      if (byte_read) begin
         rdata_d = 8'h00;
         for (int j = 0; j < NUM_REGS; j++) begin
            if (acc_addr == REG_ADDR[j] && acc_addr <= ADDR_LAST) begin
               rdata_d = regs_q[j] & REG_WMASK[j];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign byte_rdata = rdata_q;
   assign cfg_ready  = ready_q;

   // mirrored pairs: either copy asserts the mode
   assign shutdown      = regs_q[IDX_MODE][7] | regs_q[IDX_MODE][0];
   assign lsb_first     = regs_q[IDX_MODE][6] | regs_q[IDX_MODE][1];
   assign soft_reinit_n = regs_q[IDX_MODE][5] & regs_q[IDX_MODE][2];
   assign standby       = regs_q[IDX_MODE][4] | regs_q[IDX_MODE][3];

   assign independent_rate_enable = regs_q[IDX_CHAN][7];
   assign active_channel_count    = regs_q[IDX_CHAN][5:3];
   assign readback_edge_select    = regs_q[IDX_SDO][7];
   assign frame_strobe_polarity   = regs_q[IDX_SCR][7];
   assign autocal_delay_enable    = regs_q[IDX_SCR][6];
   assign scrambler_enable        = regs_q[IDX_SCR][0];
   assign eight_lane_serial_mode  = regs_q[IDX_FMT][6];
   assign sample_format           = regs_q[IDX_FMT][5];
   assign output_if_select        = regs_q[IDX_FMT][4:3];
   assign test_pattern_select     = regs_q[IDX_FMT][2:0];
   assign lane_polarity_invert    = regs_q[IDX_POL];
   assign synth_refdiv_enable     = regs_q[IDX_SEN1][4];
   assign synth_enable            = regs_q[IDX_SEN1][1];
   assign synth_filter_resistor_code = regs_q[IDX_SRES][4:0];

   chk_por_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(ready_q) |-> $past(por_cnt_q) == 21'(POR_CYCLES - 1))
      else $error("ready rose at wrong count");
   chk_pin_defaults: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rpin_s2_q |=> regs_q[IDX_MODE] == 8'h24 && regs_q[IDX_SRES] == 8'h2F)
      else $error("pin reset did not restore defaults");
   chk_addr_sat: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!cmd_start && addr_q == ADDR_LAST) |=> addr_q == ADDR_LAST)
      else $error("address counter wrapped");
   chk_addr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!cmd_start && byte_write && addr_q < ADDR_LAST) |=> addr_q == $past(addr_q) + 10'h001)
      else $error("address counter did not step");
   chk_start_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (cmd_start && (byte_write || byte_read) && cmd_addr < ADDR_LAST)
      |=> addr_q == $past(cmd_addr) + 10'h001)
      else $error("first byte did not step the address");
   chk_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !regs_q[IDX_FMT][7] && !regs_q[IDX_SRES][7] && !regs_q[IDX_SEN1][7])
      else $error("unimplemented bit set");
   chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (byte_read && acc_addr == 10'h003) |=> byte_rdata == 8'h00)
      else $error("unmapped read nonzero");
   chk_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ready_q && rpin_s2_q && rpin_s1_q && hw_reset_n_pin && byte_write && cmd_start
       && cmd_addr == 10'h065) |=> ##1 lane_polarity_invert == $past(byte_wdata, 2))
      else $error("polarity write lost");
   chk_mirror_sd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      regs_q[IDX_MODE] == 8'h24 |-> !shutdown && soft_reinit_n && !standby)
      else $error("mode default decode wrong");
   cov_ready: cover property (@(posedge clk_sys) $rose(ready_q));
   cov_burst: cover property (@(posedge clk_sys) byte_write ##1 byte_write ##1 byte_write);
   cov_pin:   cover property (@(posedge clk_sys) ready_q && !rpin_s2_q);
   cov_rd_burst: cover property (@(posedge clk_sys) cmd_start && byte_read ##1 byte_read);
endmodule : acrb_bank

// ### sim/acrb_host_model.sv
// Purpose: host side of the register command port
// Assumes: one byte per cycle, read data one cycle late
// Notes: released lines flip so stale values never look valid
`timescale 1ns/1ps
module acrb_host_model (
   input  wire logic                        clk_sys,
   output logic                             cmd_start,
   output logic [acrb_pkg::ADDR_W-1:0]      cmd_addr,
   output logic                             byte_write,
   output logic                             byte_read,
   output logic [7:0]                       byte_wdata,
   input  wire logic [7:0]                  byte_rdata
);
   import acrb_pkg::*;
   logic [7:0] rdq [4];
   initial begin
      cmd_start = 1'b0;
      cmd_addr = '0;
      byte_write = 1'b0;
      byte_read = 1'b0;
      byte_wdata = 8'h00;
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      cmd_start <= 1'b1;
      cmd_addr <= a;
      byte_write <= 1'b1;
      byte_wdata <= d;
      @(posedge clk_sys);
      cmd_start <= 1'b0;
      byte_write <= 1'b0;
      cmd_addr <= ~a;
      byte_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, input int n);
      @(posedge clk_sys);
      cmd_start <= 1'b1;
      cmd_addr <= a;
      byte_read <= 1'b1;
      for (int k = 1; k <= n + 1; k++) begin
         @(posedge clk_sys);
         cmd_start <= 1'b0;
         cmd_addr <= ~a;
         if (k == n) byte_read <= 1'b0;
         if (k > 1) rdq[k-2] = byte_rdata;
      end
   endtask : rd
endmodule : acrb_host_model

// ### sim/adc_config_register_bank_tb_top.sv
// Purpose: self-checking bench for the configuration register bank
// Assumes: power-on wait shortened to 16 clocks
// Notes: fixed seed; masked bit 7 written as one and expected to read zero
`timescale 1ns/1ps
module adc_config_register_bank_tb_top;
   import acrb_pkg::*;
   localparam int unsigned POR = 16;
   logic clk_sys, rst_n, hw_reset_n_pin, cmd_start, byte_write, byte_read, cfg_ready;
   logic shutdown, lsb_first, soft_reinit_n, standby, independent_rate_enable;
   logic readback_edge_select, frame_strobe_polarity, autocal_delay_enable, scrambler_enable;
   logic eight_lane_serial_mode, sample_format, synth_refdiv_enable, synth_enable;
   logic [ADDR_W-1:0] cmd_addr;
   logic [7:0]        byte_wdata, byte_rdata, lane_polarity_invert, d;
   logic [1:0]        output_if_select;
   logic [2:0]        active_channel_count, test_pattern_select;
   logic [4:0]        synth_filter_resistor_code;
   logic [9:0]        wa [9] = '{10'h000, 10'h001, 10'h004, 10'h007, 10'h059, 10'h05A,
                                 10'h062, 10'h065, 10'h003};
   logic [7:0]        wd [9] = '{8'h81, 8'hAF, 8'h1F, 8'hE3, 8'hD3, 8'hA0, 8'hFF, 8'h00, 8'h5A};
   logic [9:0]        ua [4] = '{10'h002, 10'h01E, 10'h054, 10'h056};
   int                miscompares, samples_checked, seed, n;
   acrb_bank #(.POR_CYCLES(POR)) DUT (.clk_sys, .rst_n, .hw_reset_n_pin, .cmd_start,
      .cmd_addr, .byte_write, .byte_read, .byte_wdata, .byte_rdata, .cfg_ready, .shutdown,
      .lsb_first, .soft_reinit_n, .standby, .independent_rate_enable, .active_channel_count,
      .readback_edge_select, .frame_strobe_polarity, .autocal_delay_enable, .scrambler_enable,
      .eight_lane_serial_mode, .sample_format, .output_if_select, .test_pattern_select,
      .lane_polarity_invert, .synth_refdiv_enable, .synth_enable, .synth_filter_resistor_code);
   acrb_host_model host (.clk_sys, .cmd_start, .cmd_addr, .byte_write, .byte_read,
      .byte_wdata, .byte_rdata);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // unmapped places read zero, refused bits read zero
   function automatic logic [7:0] rd_exp(input logic [9:0] a, input logic [7:0] v);
      rd_exp = 8'h00;
      for (int i = 0; i < NUM_REGS; i++)
         if (REG_ADDR[i] == a) rd_exp = v & REG_WMASK[i];
   endfunction : rd_exp
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      seed = 49295;
      rst_n = 1'b0;
      hw_reset_n_pin = 1'b1;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk(cfg_ready, 1'b0);
      n = 8;
      while (cfg_ready !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n >= POR && n <= POR + 3, 1'b1);
      $display("test power-on wait done");
      foreach (REG_ADDR[i]) begin
         host.rd(REG_ADDR[i], 1);
         chk(host.rdq[0], REG_RST[i]);
      end
      host.rd(10'h000, 2);
      chk(host.rdq[0], 8'h24);
      chk(host.rdq[1], 8'h0F);
      $display("test defaults done");
      wd[5] = wd[5] | (8'($random(seed)) & 8'h1F);
      wd[7] = 8'($random(seed));
      foreach (wa[i]) begin
         // the unmapped probe is only read, never written
         if (wa[i] != 10'h003) host.wr(wa[i], wd[i]);
         host.rd(wa[i], 1);
         chk(host.rdq[0], rd_exp(wa[i], wd[i]));
      end
      chk({shutdown, lsb_first, soft_reinit_n, standby, independent_rate_enable,
           active_channel_count, readback_edge_select, frame_strobe_polarity,
           autocal_delay_enable, scrambler_enable}, 12'h8D7);
      chk({eight_lane_serial_mode, sample_format, output_if_select, test_pattern_select,
           synth_refdiv_enable, synth_enable, synth_filter_resistor_code, lane_polarity_invert},
          {7'h7F, 2'b11, wd[5][4:0], wd[7]});
      repeat (8) begin
         n = $unsigned($random(seed)) % 4;
         d = 8'($random(seed));
         host.wr(ua[n], d);
         host.rd(ua[n], 1);
         chk(host.rdq[0], d);
      end
      $display("test writes done");
      hw_reset_n_pin <= 1'b0;
      repeat (6) @(posedge clk_sys);
      hw_reset_n_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({shutdown, standby, soft_reinit_n, lane_polarity_invert}, 11'h100);
      host.rd(10'h059, 2);
      chk(host.rdq[0], 8'h41);
      chk(host.rdq[1], 8'h2F);
      $display("test reset pin done");
      close_out();
   end
endmodule : adc_config_register_bank_tb_top
